// ===== core/bt_pkg.sv
// Purpose: shared constants and types for the basic timer register block
// Assumes: one instance per timer, all on the controller's internal bus
// Notes:   offsets are byte addresses within a 32-byte instance window
package bt_pkg;

   // ==========================================================
   // instance placement
   localparam logic [31:0] BT_FIRST_BASE = 32'h0000_0C00;
   localparam logic [31:0] BT_INST_STRIDE = 32'h0000_0020;
   localparam int BT_NUM_INST = 4;
   localparam int BT_WIN_LSB = 5;

   // ==========================================================
   // register offsets inside one instance
   localparam logic [4:0] BT_OFF_COUNT = 5'h00;
   localparam logic [4:0] BT_OFF_PRELOAD = 5'h04;
   localparam logic [4:0] BT_OFF_STATUS = 5'h08;
   localparam logic [4:0] BT_OFF_IEN = 5'h0C;
   localparam logic [4:0] BT_OFF_CTRL = 5'h10;

   // ==========================================================
   // field positions
   localparam int BT_EVENT_BIT = 0;
   localparam int BT_IEN_BIT = 0;
   localparam int BT_CTL_ENABLE = 0;
   localparam int BT_CTL_COUNT_UP = 2;
   localparam int BT_CTL_AUTO_RESTART = 3;
   localparam int BT_CTL_SOFT_RESET = 4;
   localparam int BT_CTL_START = 5;
   localparam int BT_CTL_RELOAD = 6;
   localparam int BT_CTL_HALT = 7;
   localparam int BT_CTL_PRE_LSB = 16;
   localparam int BT_PRE_W = 16;

   // ==========================================================
   // reset values
   localparam logic [31:0] BT_COUNT_RST = 32'h0000_0000;
   localparam logic [31:0] BT_PRELOAD_RST = 32'h0000_0000;
   localparam logic BT_STATUS_RST = 1'h0;
   localparam logic BT_IEN_RST = 1'h0;
   localparam logic [15:0] BT_PRESCALE_RST = 16'h0000;

   // ==========================================================
   // run state, gray along idle -> run -> hold
   typedef enum logic [1:0] {
      BT_IDLE = 2'b00,
      BT_RUN = 2'b01,
      BT_HOLD = 2'b11
   } bt_run_type;

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] bt_merge(input logic [31:0] old_v,
                                            input logic [31:0] wr_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wr_v[8*i +: 8];
         end
      end
      return res;
   endfunction

endpackage

// ===== core/bt_tick_if.sv
// Purpose: carries the prescaler controls and the count tick
// Assumes: both ends run on the same clock
// Notes:   clear restarts the divider from zero
`timescale 1ns/1ps
interface bt_tick_if #(
   parameter int PRE_W = 16
);
   logic [PRE_W-1:0] prescale;
   logic run;
   logic clear;
   logic tick;

   modport ctl(output prescale, output run, output clear, input tick);
   modport div(input prescale, input run, input clear, output tick);
endinterface

// ===== core/bt_prescaler.sv
// Purpose: clock-enable divider feeding the timer counter
// Assumes: prescale held stable while running
// Notes:   one tick every prescale+1 clocks; tick is registered
`timescale 1ns/1ps
module bt_prescaler
   import bt_pkg::*;
#(
   parameter int PRE_W = BT_PRE_W
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   bt_tick_if.div tk
);

   typedef struct packed {
      logic [PRE_W-1:0] div;
      logic tick;
   } bt_div_type;

   bt_div_type s_r;
   bt_div_type s_nxt;

   // ==========================================================
   // divider
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (tk.clear || !tk.run) begin
         s_nxt.div = '0;
      end else if (s_r.div == tk.prescale) begin
         s_nxt.div = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.div = s_r.div + PRE_W'(1);
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tk.tick = s_r.tick;

endmodule

// ===== core/bt_timer.sv
// Purpose: one basic timer instance with its register window
// Assumes: word or byte accesses from the controller, same clock
// Notes:   several instances may share the bus; only the hit one answers
`timescale 1ns/1ps

// Contract
// - four instances, bases step by 0x20
// - count, preload, status, enable, control offsets
// - count reads come from a snapshot
// - counter width parameter, upper bits zero
// - auto restart loads preload into counter
// - preload same width, upper bits zero
// - status bit 0 set at limit, W1C
// - pulse in auto restart, else level
// - enable bit gates status onto interrupt
// - soft reset or system reset restores defaults
// - count advances every prescale+1 clocks
module bt_timer
   import bt_pkg::*;
#(
   parameter int INSTANCE = 0,
   parameter int CNT_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [31:0] i_addr,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [3:0] i_be,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   output logic o_rd_valid,
   output logic o_irq
);

   // ==========================================================
   // elaboration checks
   generate
      if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
         $error("counter width must be 1 to 32");
      end
      if (INSTANCE < 0 || INSTANCE >= BT_NUM_INST) begin : g_bad_inst
         $error("instance number out of range");
      end
   endgenerate

   localparam logic [31:0] BASE =
      BT_FIRST_BASE + 32'(INSTANCE) * BT_INST_STRIDE;

   // ==========================================================
   // state
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] snap;
      logic [CNT_W-1:0] pre;
      logic status;
      logic ien;
      logic [BT_PRE_W-1:0] prescale;
      logic halt;
      logic auto_restart;
      logic count_up;
      logic enable;
      bt_run_type state;
      logic div_clr;
      logic [31:0] rdata;
      logic rvalid;
      logic irq;
   } bt_state_type;

   bt_state_type s_r;
   bt_state_type s_nxt;

   bt_tick_if #(.PRE_W(BT_PRE_W)) tk();

   // ==========================================================
   // helpers
   function automatic logic at_limit(input logic [CNT_W-1:0] c,
                                     input logic up);
      logic res;
      if (up) begin
         res = (c == {CNT_W{1'b1}});
      end else begin
         res = (c == '0);
      end
      return res;
   endfunction

   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      return 32'(v);
   endfunction

   // ==========================================================
   // address decode
   logic hit;
   logic [4:0] off;
   logic wr_hit;
   logic rd_hit;

   always_comb begin
      hit = (i_addr[31:BT_WIN_LSB] == BASE[31:BT_WIN_LSB]);
      off = {i_addr[4:2], 2'b00};
      wr_hit = i_wr_en && hit;
      rd_hit = i_rd_en && hit;
   end

   // control word as it reads back
   logic [31:0] ctrl_rd;

   always_comb begin
      ctrl_rd = '0;
      ctrl_rd[BT_CTL_PRE_LSB +: BT_PRE_W] = s_r.prescale;
      ctrl_rd[BT_CTL_HALT] = s_r.halt;
      ctrl_rd[BT_CTL_START] = (s_r.state != BT_IDLE);
      ctrl_rd[BT_CTL_AUTO_RESTART] = s_r.auto_restart;
      ctrl_rd[BT_CTL_COUNT_UP] = s_r.count_up;
      ctrl_rd[BT_CTL_ENABLE] = s_r.enable;
   end

   // ==========================================================
   // next state
   logic [31:0] wval;
   logic hit_limit;
   logic running;
   logic start_new;

   always_comb begin
      s_nxt = s_r;
      wval = '0;
      start_new = 1'b0;
      s_nxt.rvalid = 1'b0;
      s_nxt.div_clr = 1'b0;
      running = (s_r.state == BT_RUN) && s_r.enable;
      hit_limit = running && tk.tick && at_limit(s_r.cnt, s_r.count_up);

      // a pulse only lives for one cycle in restart mode
      if (s_r.auto_restart) begin
         s_nxt.status = 1'b0;
      end

      // ---- counting
      if (running && tk.tick) begin
         if (hit_limit) begin
            s_nxt.status = 1'b1;
            if (s_r.auto_restart) begin
               s_nxt.cnt = s_r.pre;
            end else begin
               s_nxt.state = BT_IDLE;
            end
         end else if (s_r.count_up) begin
            s_nxt.cnt = s_r.cnt + CNT_W'(1);
         end else begin
            s_nxt.cnt = s_r.cnt - CNT_W'(1);
         end
      end

      // ---- register writes
      if (wr_hit) begin
         case (off)
            BT_OFF_COUNT: begin
               // a write while counting overrides the hardware step
               wval = bt_merge(widen(s_r.cnt), i_wdata, i_be);
               s_nxt.cnt = wval[CNT_W-1:0];
            end
            BT_OFF_PRELOAD: begin
               wval = bt_merge(widen(s_r.pre), i_wdata, i_be);
               s_nxt.pre = wval[CNT_W-1:0];
            end
            BT_OFF_STATUS: begin
               // a limit event in the same cycle wins over the clear
               if (i_be[0] && i_wdata[BT_EVENT_BIT] && !hit_limit) begin
                  s_nxt.status = 1'b0;
               end
            end
            BT_OFF_IEN: begin
               if (i_be[0]) begin
                  s_nxt.ien = i_wdata[BT_IEN_BIT];
               end
            end
            BT_OFF_CTRL: begin
               wval = bt_merge(ctrl_rd, i_wdata, i_be);
               s_nxt.prescale = wval[BT_CTL_PRE_LSB +: BT_PRE_W];
               s_nxt.halt = wval[BT_CTL_HALT];
               s_nxt.auto_restart = wval[BT_CTL_AUTO_RESTART];
               s_nxt.count_up = wval[BT_CTL_COUNT_UP];
               s_nxt.enable = wval[BT_CTL_ENABLE];
               start_new = wval[BT_CTL_START];
               if (!start_new) begin
                  s_nxt.state = BT_IDLE;
               end else if (s_r.state == BT_IDLE) begin
                  // fresh start: divider restarts, events cleared
                  s_nxt.state = BT_RUN;
                  s_nxt.div_clr = 1'b1;
                  s_nxt.status = 1'b0;
               end else if (wval[BT_CTL_RELOAD]) begin
                  s_nxt.cnt = s_r.pre;
               end
            end
            default: begin
               wval = '0;
            end
         endcase
      end

      // ---- halt holds the count and clears the divider
      case (s_nxt.state)
         BT_RUN: begin
            if (s_nxt.halt) begin
               s_nxt.state = BT_HOLD;
               s_nxt.div_clr = 1'b1;
            end
         end
         BT_HOLD: begin
            if (!s_nxt.halt) begin
               s_nxt.state = BT_RUN;
            end
         end
         BT_IDLE: begin
            s_nxt.state = BT_IDLE;
         end
         default: begin
            s_nxt.state = BT_IDLE;
         end
      endcase

      // ---- register reads, one cycle later
      if (rd_hit) begin
         s_nxt.rvalid = 1'b1;
         case (off)
            BT_OFF_COUNT: begin
               // lane 0 takes a fresh copy; upper lanes read the copy
               if (i_be[0]) begin
                  s_nxt.snap = s_r.cnt;
                  s_nxt.rdata = widen(s_r.cnt);
               end else begin
                  s_nxt.rdata = widen(s_r.snap);
               end
            end
            BT_OFF_PRELOAD: begin
               s_nxt.rdata = widen(s_r.pre);
            end
            BT_OFF_STATUS: begin
               s_nxt.rdata = 32'(s_r.status);
            end
            BT_OFF_IEN: begin
               s_nxt.rdata = 32'(s_r.ien);
            end
            BT_OFF_CTRL: begin
               s_nxt.rdata = ctrl_rd;
            end
            default: begin
               s_nxt.rdata = '0;
            end
         endcase
      end

      // ---- soft reset restores everything, read answer included
      if (wr_hit && off == BT_OFF_CTRL && wval[BT_CTL_SOFT_RESET]) begin
         s_nxt = '0;
         s_nxt.cnt = BT_COUNT_RST[CNT_W-1:0];
         s_nxt.pre = BT_PRELOAD_RST[CNT_W-1:0];
         s_nxt.status = BT_STATUS_RST;
         s_nxt.ien = BT_IEN_RST;
         s_nxt.prescale = BT_PRESCALE_RST;
         s_nxt.state = BT_IDLE;
         s_nxt.div_clr = 1'b1;
      end

      s_nxt.irq = s_nxt.status & s_nxt.ien;
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // prescaler hookup
   assign tk.prescale = s_r.prescale;
   assign tk.run = (s_r.state == BT_RUN) && s_r.enable;
   assign tk.clear = s_r.div_clr;

   bt_prescaler #(
      .PRE_W(BT_PRE_W)
   ) u_div (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .tk(tk)
   );

   // ==========================================================
   // outputs
   assign o_rdata = s_r.rdata;
   assign o_rd_valid = s_r.rvalid;
   assign o_irq = s_r.irq;

endmodule

// ===== bench/bt_monitor.sv
// Purpose: port checks for one bt_timer instance
// Assumes: single clock, asynchronous active-high reset
// Notes: mirrors enable and auto restart from observed writes
`timescale 1ns/1ps
module bt_monitor
   import bt_pkg::*;
#(
   parameter int INSTANCE = 0,
   parameter int CNT_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [31:0] i_addr,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [3:0] i_be,
   input wire logic [31:0] i_wdata,
   input wire logic [31:0] o_rdata,
   input wire logic o_rd_valid,
   input wire logic o_irq
);
   localparam logic [31:0] BASE = 32'(BT_FIRST_BASE + INSTANCE * 32);
   logic hit;
   logic wr_ctl;
   logic ien_r;
   logic auto_r;
   assign hit = i_addr[31:5] == BASE[31:5];
   assign wr_ctl = i_wr_en && hit && i_be[0] && i_addr[4:0] == BT_OFF_CTRL;
   // soft reset drops both mirrors, like the block itself
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         ien_r <= 1'b0;
         auto_r <= 1'b0;
      end else if (wr_ctl) begin
         ien_r <= ien_r & ~i_wdata[4];
         auto_r <= i_wdata[3] & ~i_wdata[4];
      end else if (i_wr_en && hit && i_be[0]
                   && i_addr[4:0] == BT_OFF_IEN) begin
         ien_r <= i_wdata[0];
      end
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   rd_answer_a: assert property (
      i_rd_en && hit && !wr_ctl |=> o_rd_valid)
      else $error("read in window got no answer");
   rd_source_a: assert property (
      o_rd_valid |-> $past(i_rd_en && hit))
      else $error("answer without a read in window");
   rdata_hold_a: assert property (
      !o_rd_valid && !$past(wr_ctl) |-> $stable(o_rdata))
      else $error("read data moved without a read");
   upper_zero_a: assert property (
      o_rd_valid && $past(i_addr[4:3]) == 2'b00
      |-> (o_rdata >> CNT_W) == 32'h0)
      else $error("bits above width set");
   flag_bits_a: assert property (
      o_rd_valid && $past(i_addr[4:3]) == 2'b01
      |-> o_rdata[31:1] == 31'h0)
      else $error("status upper bits set");
   reserved_zero_a: assert property (
      o_rd_valid && $past(i_addr[4:2]) > 3'h4
      |-> o_rdata == 32'h0)
      else $error("reserved offset not zero");
   irq_gate_a: assert property (o_irq |-> ien_r || $past(ien_r))
      else $error("interrupt while disabled");
   irq_pulse_a: assert property (o_irq && auto_r |=> !o_irq)
      else $error("auto restart event longer than a cycle");
   reset_quiet_a: assert property (
      $fell(i_reset) |-> !o_rd_valid && !o_irq)
      else $error("outputs active after reset");
   soft_reset_a: assert property (
      wr_ctl && i_wdata[4] |=> !o_rd_valid && !o_irq ##1 !o_irq)
      else $error("soft reset left outputs active");
   cover property (o_irq && auto_r);
   cover property (o_irq && !auto_r);
   cover property (wr_ctl && i_wdata[4]);
endmodule

bind bt_timer bt_monitor #(.INSTANCE(INSTANCE), .CNT_W(CNT_W)) u_bt_monitor (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_be(i_be), .i_wdata(i_wdata),
   .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_irq(o_irq));

// ===== bench/testbench.sv
// Purpose: self-checking bench for one bt_timer instance
// Assumes: inputs move 1 ns after the rising edge
// Notes: reads queue their expected lanes; a watcher compares answers
`timescale 1ns/1ps
module testbench;
   import bt_pkg::*;
   localparam int INST = 2;
   localparam logic [31:0] BASE = 32'(BT_FIRST_BASE + INST * 32);
   localparam logic [31:0] MASK = 32'h0000_FFFF;
   logic i_mclk = 1'b0;
   logic i_reset = 1'b1;
   logic [31:0] i_addr = 32'h0;
   logic i_wr_en = 1'b0;
   logic i_rd_en = 1'b0;
   logic [3:0] i_be = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [31:0] o_rdata;
   logic o_rd_valid;
   logic o_irq;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int t;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] p;
   logic [31:0] v;
   logic [31:0] seen;

   bt_timer #(.INSTANCE(INST), .CNT_W(16)) u_bt_timer (
      .i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_be(i_be),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .o_irq(o_irq));

   initial begin
      forever #20 i_mclk = ~i_mclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string nm, input logic [31:0] got,
                        input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic final_report();
      if (err_total == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // bus driving: aligned words or byte lanes only
   task automatic bus(input logic wr, input logic rd, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      i_wr_en = wr;
      i_rd_en = rd;
      i_addr = a;
      i_wdata = d;
      i_be = be;
      @(posedge i_mclk);
      #1;
   endtask

   task automatic wr(input logic [4:0] off, input logic [31:0] d);
      bus(1'b1, 1'b0, BASE + 32'(off), d, 4'hF);
   endtask

   task automatic rd(input logic [4:0] off, input logic [3:0] be,
                     input logic [31:0] e);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      bus(1'b0, 1'b1, BASE + 32'(off), 32'h0, be);
   endtask

   task automatic idle(input int n);
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      repeat (n) @(posedge i_mclk);
      #1;
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      while (o_irq !== 1'b1 && n < 3000) begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      check("irq raised", {31'h0, o_irq}, 32'h1);
   endtask

   // ==========================================================
   // answer watcher and timeout
   always @(negedge i_mclk) begin
      if (o_rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unasked answer", 32'h1, 32'h0);
         end else begin
            seen = o_rdata & msk_q.pop_front();
            check("read data", seen, exp_q.pop_front());
         end
      end
   end

   // longest wait is the 1100-clock masked window, just over one timer period of 1024 clocks
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total++;
         final_report();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge i_mclk);
      #1;
      i_reset = 1'b0;
      for (int k = 0; k < 4; k++) rd(5'(4 * k), 4'hF, 32'h0);
      p = lfsr_next(32'h8175C897);
      v = lfsr_next(p);
      wr(BT_OFF_PRELOAD, p);
      wr(BT_OFF_COUNT, v);
      rd(BT_OFF_PRELOAD, 4'hF, p & MASK);
      rd(BT_OFF_COUNT, 4'hF, v & MASK);
      for (int k = 5; k < 8; k++) begin
         wr(5'(4 * k), 32'hFFFF_FFFF);
         rd(5'(4 * k), 4'hF, 32'h0);
      end
      bus(1'b0, 1'b1, BASE + BT_INST_STRIDE, 32'h0, 4'hF);
      wr(BT_OFF_COUNT, 32'h1234);
      rd(BT_OFF_COUNT, 4'h1, 32'h1234);
      wr(BT_OFF_COUNT, 32'h5678);
      rd(BT_OFF_COUNT, 4'h2, 32'h1234);
      rd(BT_OFF_COUNT, 4'hF, 32'h5678);
      // one-shot down count from 2 leaves a level
      wr(BT_OFF_IEN, 32'h1);
      wr(BT_OFF_COUNT, 32'h2);
      wr(BT_OFF_CTRL, 32'h0000_0021);
      idle(1);
      wait_irq(t);
      idle(4);
      check("irq level", {31'h0, o_irq}, 32'h1);
      rd(BT_OFF_STATUS, 4'hF, 32'h1);
      bus(1'b1, 1'b0, BASE + BT_OFF_STATUS, 32'h1, 4'h1);
      rd(BT_OFF_STATUS, 4'hF, 32'h0);
      idle(1);
      check("irq cleared", {31'h0, o_irq}, 32'h0);
      // auto restart, preload 3, prescale 255: event every 4 ticks
      wr(BT_OFF_COUNT, 32'h1);
      wr(BT_OFF_PRELOAD, 32'h3);
      wr(BT_OFF_CTRL, 32'h00FF_0029);
      idle(1);
      wait_irq(t);
      idle(1);
      check("irq pulse", {31'h0, o_irq}, 32'h0);
      wait_irq(t);
      check("event spacing", 32'(t), 32'(4 * 256 - 1));
      rd(BT_OFF_COUNT, 4'hF, 32'h3);
      rd(BT_OFF_STATUS, 4'hF, 32'h0);
      wr(BT_OFF_IEN, 32'h0);
      idle(1);
      t = 0;
      repeat (1100) begin
         @(posedge i_mclk);
         #1;
         if (o_irq === 1'b1) t++;
      end
      check("masked irq", 32'(t), 32'h0);
      wr(BT_OFF_IEN, 32'h1);
      bus(1'b1, 1'b0, BASE + BT_OFF_CTRL, 32'h10, 4'h1);
      rd(BT_OFF_PRELOAD, 4'hF, 32'h0);
      rd(BT_OFF_IEN, 4'hF, 32'h0);
      rd(BT_OFF_CTRL, 4'hF, 32'h0);
      // up count held by halt, then released to a one-shot limit
      wr(BT_OFF_IEN, 32'h1);
      wr(BT_OFF_COUNT, 32'hFFF0);
      wr(BT_OFF_CTRL, 32'h0000_00A5);
      idle(4);
      rd(BT_OFF_COUNT, 4'hF, 32'hFFF0);
      wr(BT_OFF_CTRL, 32'h0000_0025);
      wait_irq(t);
      // 15 steps to all ones, one tick at the limit, one divider start
      check("up count cycles", 32'(t), 32'(17));
      rd(BT_OFF_COUNT, 4'hF, 32'hFFFF);
      rd(BT_OFF_CTRL, 4'hF, 32'h0000_0005);
      bus(1'b1, 1'b0, BASE + BT_OFF_STATUS, 32'h1, 4'h1);
      // manual reload while held
      wr(BT_OFF_PRELOAD, 32'hABCD);
      wr(BT_OFF_CTRL, 32'h0000_00A5);
      wr(BT_OFF_CTRL, 32'h0000_00E5);
      rd(BT_OFF_COUNT, 4'hF, 32'hABCD);
      rd(BT_OFF_CTRL, 4'hF, 32'h0000_00A5);
      idle(3);
      check("pending reads", 32'(exp_q.size()), 32'h0);
      final_report();
   end
endmodule
